// File: rtl/scg_device.sv
// correction generator: serial register loader and waveform engine
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// - clock halve select divides internal rate
// - host selects halving above 41 MHz
// - sync edge polarity is programmable
// - vertical start 20 clocks after sync
// - horizontal start follows sync leading edge
// - 1.5 lines between vertical start, video
// - clear high initialises all state except the point memories
// - horizontal output starts at programmed offset
// - hold each point interval plus one ticks, no interpolation
// - words latched on returned dac clock
// - vertical interpolation, spacing calc times point
// - main address, sub address, then data bytes
// - main address is a block bit mask
// - write address increments per data byte
// - bits select memories zero to two, timing
// - memory n drives channel n only
// - 208 six-bit words, upper bits ignored
// - off level output during serial transfer
// - correction off outputs off level
// - standby stops engine, outputs high impedance
// - low flip reverses read; pins override
module scg_device
  import scg_pkg::*;
(
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic         clock_halve_select_i,
  input  wire logic         horizontal_sync_i,
  input  wire logic         vertical_start_pulse_i,
  input  wire logic         horizontal_start_pulse_i,
  input  wire logic         vertical_flip_i,
  input  wire logic         horizontal_flip_i,
  input  wire logic         flip_source_select_i,
  input  wire logic         dac_clock_in_i,
  scg_link_if.device        link,
  output logic [17:0]       dac_word_o,
  output logic              outputs_oe_n_o
);
  // ===========================================================
  // state
  typedef struct packed {
    logic        div_q;
    logic        sclk_q;
    logic        frame_q;
    logic [2:0]  bit_cnt_q;
    logic [7:0]  shift_q;
    logic [1:0]  phase_q;
    logic [3:0]  mask_q;
    logic [7:0]  addr_q;
    logic [NUM_TIMING_REGS-1:0][7:0] regs_q;
    logic        hs_q;
    logic        vs_q;
    logic [8:0]  hoff_cnt_q;
    logic        hrun_q;
    logic [7:0]  hint_cnt_q;
    logic [3:0]  hpt_q;
    logic [3:0]  vrow_q;
    logic [11:0] frac_q;
    logic [4:0]  vcalc_q;
    logic [3:0]  voff_q;
    logic        dack_q;
    logic [17:0] word_q;
    logic        oe_n_q;
  } scg_state_t;
  scg_state_t s_q, s_d;
  // point memories
  logic [WORD_W-1:0] mem [3][MEM_WORDS];
  logic              mem_we;
  logic [2:0]        mem_sel;
  logic [7:0]        mem_addr;
  logic [5:0]        mem_data;
  function automatic logic [7:0] grid_addr(input logic [3:0] row,
                                           input logic [3:0] col);
    grid_addr = 8'({row, col});
  endfunction : grid_addr
  // ===========================================================
  // combinational next state
  logic        tick;
  logic        sclk_rise;
  logic        hs_lead;
  logic        vs_lead;
  logic        standby;
  logic        vflip;
  logic        hflip;
  logic [3:0]  rd_row;
  logic [3:0]  rd_row2;
  logic [3:0]  rd_col;
  logic [17:0] calc;
  logic [12:0] diff;
  logic signed [19:0] prod;
  always_comb begin
    s_d       = s_q;
    mem_we    = 1'b0;
    mem_sel   = 3'h0;
    mem_addr  = s_q.addr_q;
    mem_data  = 6'(s_q.shift_q);
    standby   = (s_q.regs_q[9][7:6] == STANDBY_CODE);
    s_d.div_q = ~s_q.div_q;
    tick      = ~clock_halve_select_i | s_q.div_q;
    s_d.sclk_q  = link.serial_clock;
    s_d.frame_q = link.serial_frame_ctrl;
    sclk_rise   = link.serial_clock & ~s_q.sclk_q;
    if (link.serial_frame_ctrl) begin
      s_d.bit_cnt_q = 3'h0;
      s_d.phase_q   = 2'h0;
    end else if (sclk_rise) begin
      s_d.shift_q   = {s_q.shift_q[6:0], link.serial_data_in};
      s_d.bit_cnt_q = s_q.bit_cnt_q + 3'h1;
      if (s_q.bit_cnt_q == 3'h7) begin
        mem_data = 6'(s_d.shift_q);
        case (s_q.phase_q)
          2'h0: begin
            s_d.mask_q  = s_d.shift_q[3:0];
            s_d.phase_q = 2'h1;
          end
          2'h1: begin
            s_d.addr_q  = s_d.shift_q;
            s_d.phase_q = 2'h2;
          end
          default: begin
            mem_we  = (s_q.addr_q < 8'(MEM_WORDS));
            mem_sel = s_q.mask_q[2:0];
            if (s_q.mask_q[MA_TIMING_BIT] &&
                s_q.addr_q < 8'(NUM_TIMING_REGS))
              s_d.regs_q[s_q.addr_q] = s_d.shift_q;
            s_d.addr_q = s_q.addr_q + 8'h1;
          end
        endcase
      end
    end
    vflip  = flip_source_select_i ? vertical_flip_i
                                  : s_q.regs_q[8][OC_VFLIP_BIT];
    hflip  = flip_source_select_i ? horizontal_flip_i
                                  : s_q.regs_q[8][OC_HFLIP_BIT];
    rd_row = vflip ? s_q.vrow_q : 4'(V_POINTS - 1) - s_q.vrow_q;
    rd_row2 = (rd_row == 4'(V_POINTS - 1)) ? rd_row
            : (vflip ? rd_row + 4'h1 : rd_row - 4'h1);
    if (!vflip && rd_row == 4'h0)
      rd_row2 = rd_row;
    rd_col = hflip ? s_q.hpt_q : 4'hf - s_q.hpt_q;
    // sync polarity, sampled on ticks so no lead edge is lost
    if (tick) begin
      s_d.hs_q = horizontal_sync_i ^ ~s_q.regs_q[8][OC_SYNC_POL_BIT];
      s_d.vs_q = vertical_start_pulse_i ^ ~s_q.regs_q[8][OC_VST_POL_BIT];
    end
    hs_lead  = s_d.hs_q & ~s_q.hs_q;
    vs_lead  = s_d.vs_q & ~s_q.vs_q;
    // horizontal start pulse not needed internally
    if (tick && !standby) begin
      if (vs_lead) begin
        s_d.vrow_q  = 4'h0;
        s_d.frac_q  = 12'h0;
        s_d.vcalc_q = 5'h0;
        s_d.voff_q  = s_q.regs_q[4][3:0];
      end
      if (hs_lead) begin
        s_d.hoff_cnt_q = 9'h0;
        s_d.hrun_q     = 1'b0;
        // line step per vertical calc interval
        if (s_q.voff_q != 4'h0)
          s_d.voff_q = s_q.voff_q - 4'h1;
        else if (s_q.vcalc_q + 5'h1 >= s_q.regs_q[5][4:0]) begin
          s_d.vcalc_q = 5'h0;
          if ({1'b0, s_q.frac_q} + 13'(s_q.regs_q[7][6:0])
              >= 13'h1000 && s_q.vrow_q < 4'(V_POINTS - 1)) begin
            s_d.vrow_q = s_q.vrow_q + 4'h1;
            s_d.frac_q = 12'(s_q.frac_q + 12'(s_q.regs_q[7][6:0]));
          end else
            s_d.frac_q = 12'(s_q.frac_q + 12'(s_q.regs_q[7][6:0]));
        end else
          s_d.vcalc_q = s_q.vcalc_q + 5'h1;
      end else if (!s_q.hrun_q) begin
        s_d.hoff_cnt_q = s_q.hoff_cnt_q + 9'h1;
        if (s_q.hoff_cnt_q == {1'b0, s_q.regs_q[2]}) begin
          s_d.hrun_q     = 1'b1;
          s_d.hpt_q      = 4'h0;
          s_d.hint_cnt_q = 8'h0;
        end
      end else begin
        if (s_q.hint_cnt_q == s_q.regs_q[3]) begin
          s_d.hint_cnt_q = 8'h0;
          if (s_q.hpt_q != 4'hf)
            s_d.hpt_q = s_q.hpt_q + 4'h1;
        end else
          s_d.hint_cnt_q = s_q.hint_cnt_q + 8'h1;
      end
    end
    s_d.dack_q = dac_clock_in_i;
    for (int ch = 0; ch < 3; ch++) begin
      diff = 13'({7'h0, mem[ch][grid_addr(rd_row2, rd_col)]})
           - 13'({7'h0, mem[ch][grid_addr(rd_row, rd_col)]});
      // wide product: 63 times 4095 overflows 18 bits
      prod = $signed({{7{diff[12]}}, diff}) *
             $signed({8'h0, s_q.frac_q});
      calc = 18'(mem[ch][grid_addr(rd_row, rd_col)]) +
             18'(prod >>> 12);
      if (!s_q.frame_q || !s_q.regs_q[8][OC_CORRECTION_ON_BIT])
        calc = 18'(s_q.regs_q[9][5:0]);
      if (dac_clock_in_i && !s_q.dack_q && !standby)
        s_d.word_q[ch*6 +: 6] = calc[5:0];
    end
    s_d.oe_n_q = standby;
  end
  // ===========================================================
  // registers and memory writes
  // clear initialises
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s_q                                  <= '0;
      s_q.frame_q                          <= 1'b1;
      s_q.hs_q                             <= 1'b0;
      s_q.regs_q[REG_OUTPUT_CONTROL]       <= OUTPUT_CONTROL_RST;
      s_q.regs_q[REG_STANDBY_OFF_LEVEL]    <= STANDBY_RST;
      s_q.regs_q[REG_VERT_CALC_INTERVAL]   <= 8'h01;
    end else begin
      s_q <= s_d;
    end
  end
  always_ff @(posedge clock_i) begin
    for (int ch = 0; ch < 3; ch++)
      if (mem_we && mem_sel[ch])
        mem[ch][mem_addr] <= mem_data;
  end
  assign dac_word_o     = s_q.word_q;
  assign outputs_oe_n_o = s_q.oe_n_q;
endmodule : scg_device
`default_nettype wire

// File: rtl/scg_pkg.sv
// package: shading correction generator constants
package scg_pkg;
  // ===========================================================
  // main address block bits
  localparam int MA_MEM0_BIT = 0;
  localparam int MA_MEM1_BIT = 1;
  localparam int MA_MEM2_BIT = 2;
  localparam int MA_TIMING_BIT = 3;
  // ===========================================================
  // timing register sub addresses
  localparam logic [7:0] REG_HORIZ_POINT_RANGE    = 8'h00;
  localparam logic [7:0] REG_VERT_POINT_RANGE     = 8'h01;
  localparam logic [7:0] REG_HORIZ_OUTPUT_OFFSET  = 8'h02;
  localparam logic [7:0] REG_HORIZ_POINT_INTERVAL = 8'h03;
  localparam logic [7:0] REG_VERT_OUTPUT_OFFSET   = 8'h04;
  localparam logic [7:0] REG_VERT_CALC_INTERVAL   = 8'h05;
  localparam logic [7:0] REG_VERT_POINT_SPACING   = 8'h06;
  localparam logic [7:0] REG_SPACING_RECIPROCAL   = 8'h07;
  localparam logic [7:0] REG_OUTPUT_CONTROL       = 8'h08;
  localparam logic [7:0] REG_STANDBY_OFF_LEVEL    = 8'h09;
  localparam int         NUM_TIMING_REGS          = 10;
  // ===========================================================
  // output_control fields
  localparam int OC_CORRECTION_ON_BIT = 7;
  localparam int OC_SYNC_POL_BIT      = 6;
  localparam int OC_VST_POL_BIT       = 5;
  localparam int OC_VFLIP_BIT         = 4;
  localparam int OC_HFLIP_BIT         = 3;
  // standby field (bits 7:6) and off level (5:0)
  localparam logic [1:0] STANDBY_CODE = 2'b10;
  // ===========================================================
  // memory geometry
  localparam int MEM_WORDS = 208;
  localparam int H_POINTS  = 16;
  localparam int V_POINTS  = 13;
  localparam int WORD_W    = 6;
  // reset values of control registers
  localparam logic [7:0] OUTPUT_CONTROL_RST = 8'h98;
  localparam logic [7:0] STANDBY_RST        = 8'h00;
endpackage : scg_pkg

// File: rtl/scg_link_if.sv
// interface: three-wire serial link between host and correction generator
`timescale 1ns/1ps
`default_nettype none
interface scg_link_if;
  logic serial_clock;
  logic serial_frame_ctrl;
  logic serial_data_in;
  modport host (output serial_clock, output serial_frame_ctrl,
                output serial_data_in);
  modport device (input serial_clock, input serial_frame_ctrl,
                  input serial_data_in);
endinterface : scg_link_if
`default_nettype wire

// File: rtl/scg_host.sv
// host end: sends one serial transfer per command
`timescale 1ns/1ps
`default_nettype none
module scg_host
  import scg_pkg::*;
#(
  parameter int HALF_BIT = 4
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [7:0]  main_addr_i,
  input  wire logic [7:0]  sub_addr_i,
  input  wire logic [7:0]  data_i,
  output logic             busy_o,
  scg_link_if.host         link
);
  // half bit count must fit the 8-bit phase counter
  if (HALF_BIT < 2 || HALF_BIT > 256) begin : g_half_bit_check
    $error("HALF_BIT out of range");
  end
  typedef enum logic [2:0] {
    H_IDLE = 3'b001, H_SHIFT = 3'b010, H_END = 3'b100
  } scg_hstate_t;
  typedef struct packed {
    scg_hstate_t st;
    logic [23:0] sh;
    logic [4:0]  nbit;
    logic [7:0]  cnt;
    logic        sclk;
    logic        frame;
  } scg_host_t;
  scg_host_t h_q, h_d;
  // ===========================================================
  // three bytes, main, sub, data
  // msb first, data set while clock low
  always_comb begin
    h_d = h_q;
    case (h_q.st)
      H_IDLE: begin
        if (start_i) begin
          h_d.sh    = {main_addr_i, sub_addr_i, data_i};
          h_d.nbit  = 5'd0;
          h_d.cnt   = 8'h0;
          h_d.frame = 1'b0;
          h_d.st    = H_SHIFT;
        end
      end
      H_SHIFT: begin
        h_d.cnt = h_q.cnt + 8'h1;
        if (h_q.cnt == 8'(HALF_BIT - 1)) begin
          h_d.cnt  = 8'h0;
          h_d.sclk = ~h_q.sclk;
          if (h_q.sclk) begin
            h_d.sh   = {h_q.sh[22:0], 1'b0};
            h_d.nbit = h_q.nbit + 5'd1;
            if (h_q.nbit == 5'd23)
              h_d.st = H_END;
          end
        end
      end
      default: begin
        h_d.cnt = h_q.cnt + 8'h1;
        if (h_q.cnt == 8'(HALF_BIT - 1)) begin
          h_d.frame = 1'b1;
          h_d.st    = H_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      h_q       <= '0;
      h_q.st    <= H_IDLE;
      h_q.frame <= 1'b1;
    end else begin
      h_q <= h_d;
    end
  end
  assign busy_o                 = (h_q.st != H_IDLE);
  assign link.serial_clock      = h_q.sclk;
  assign link.serial_frame_ctrl = h_q.frame;
  assign link.serial_data_in    = h_q.sh[23];
endmodule : scg_host
`default_nettype wire

// File: bench/scg_link_chk.sv
// checker: serial link framing and bit timing
`timescale 1ns/1ps
`default_nettype none
module scg_link_chk #(
  parameter int HALF_BIT = 4
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic serial_clock,
  input wire logic serial_frame_ctrl,
  input wire logic serial_data_in
);
  logic       sclk_q;
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic [5:0] rise_q;
  // ==========================================
  // helper counters: phase widths, rises per frame
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sclk_q <= 1'b0;
      hi_q   <= 8'h00;
      lo_q   <= 8'h00;
      rise_q <= 6'h00;
    end else begin
      sclk_q <= serial_clock;
      hi_q   <= serial_clock ? hi_q + 8'h01 : 8'h00;
      lo_q   <= (serial_clock | serial_frame_ctrl) ? 8'h00 : lo_q + 8'h01;
      if (serial_frame_ctrl)
        rise_q <= 6'h00;
      else if (serial_clock & ~sclk_q)
        rise_q <= rise_q + 6'h01;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  property p_reset_idle;
    $fell(rst_i) |-> serial_frame_ctrl && !serial_clock;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("link not idle after reset");
  property p_idle_low;
    serial_frame_ctrl |-> !serial_clock;
  endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("serial clock high outside frame");
  property p_high_width;
    $fell(serial_clock) |-> hi_q == HALF_BIT;
  endproperty
  a_high_width: assert property (p_high_width)
    else $error("serial clock high phase wrong length");
  property p_low_width;
    $rose(serial_clock) |-> lo_q == HALF_BIT;
  endproperty
  a_low_width: assert property (p_low_width)
    else $error("serial clock low phase wrong length");
  property p_data_stable;
    serial_clock && $past(serial_clock) |-> $stable(serial_data_in);
  endproperty
  a_data_stable: assert property (p_data_stable)
    else $error("data moved while serial clock high");
  property p_byte_count;
    $rose(serial_frame_ctrl) |-> rise_q == 6'd24;
  endproperty
  a_byte_count: assert property (p_byte_count)
    else $error("frame did not carry three bytes");
  property p_first_bit;
    $fell(serial_frame_ctrl) |-> ##[1:20] $rose(serial_clock);
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("no serial clock after frame start");
  property p_frame_end;
    $fell(serial_frame_ctrl) |-> ##[24:1000] $rose(serial_frame_ctrl);
  endproperty
  a_frame_end: assert property (p_frame_end)
    else $error("frame did not end in time");
  c_frame_start: cover property ($fell(serial_frame_ctrl));
  c_frame_end: cover property ($rose(serial_frame_ctrl));
  c_bit: cover property ($rose(serial_clock));
endmodule : scg_link_chk
`default_nettype wire

// File: bench/test_shading_correction_generator.sv
// testbench: host and device joined over the serial link
`timescale 1ns/1ps
`default_nettype none
module test_shading_correction_generator import scg_pkg::*;;
  localparam int HB = 2;
  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  logic        start_i = 1'b0;
  logic [7:0]  main_a  = 8'h00;
  logic [7:0]  sub_a   = 8'h00;
  logic [7:0]  data    = 8'h00;
  logic        hsync   = 1'b0;
  logic        vertical_start_pulse     = 1'b0;
  logic        dac_clk = 1'b0;
  // 100 MHz master clock needs halving
  logic        halve     = 1'b1;
  logic        flip_sel  = 1'b0;
  logic        hflip_pin = 1'b1;
  logic        vflip_pin = 1'b1;
  logic        busy;
  logic [17:0] word;
  logic        oe_n;
  int          ln = 0;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  always #5 clock_i = ~clock_i;
  scg_link_if scg_link_if_i ();
  scg_host #(.HALF_BIT(HB)) scg_host_i (
    .clock_i(clock_i), .rst_i(rst_i), .start_i(start_i),
    .main_addr_i(main_a), .sub_addr_i(sub_a), .data_i(data),
    .busy_o(busy), .link(scg_link_if_i));
  // start pulse held high, no eliminator
  scg_device scg_device_i (
    .clock_i(clock_i), .rst_i(rst_i), .clock_halve_select_i(halve),
    .horizontal_sync_i(hsync), .vertical_start_pulse_i(vertical_start_pulse),
    .horizontal_start_pulse_i(1'b1), .vertical_flip_i(vflip_pin),
    .horizontal_flip_i(hflip_pin), .flip_source_select_i(flip_sel),
    .dac_clock_in_i(dac_clk), .link(scg_link_if_i),
    .dac_word_o(word), .outputs_oe_n_o(oe_n));
  scg_link_chk #(.HALF_BIT(HB)) scg_link_chk_i (
    .clock_i(clock_i), .rst_i(rst_i),
    .serial_clock(scg_link_if_i.serial_clock),
    .serial_frame_ctrl(scg_link_if_i.serial_frame_ctrl),
    .serial_data_in(scg_link_if_i.serial_data_in));
  // start 50 clocks, 25 ticks, after sync
  // many lines pass before any video
  always @(posedge clock_i) begin
    ln <= (ln == 3199) ? 0 : ln + 1;
    hsync <= (ln % 200) < 10;
    vertical_start_pulse <= ln >= 50 && ln < 250;
  end
  // ==========================================
  // compare tasks and run end
  task automatic chk_flag(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_flag
  task automatic chk_word(input string nm, input logic [17:0] e);
    samples_checked++;
    if (word !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, word);
    end
  endtask : chk_word
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // ==========================================
  // access tasks
  task automatic dac_latch;
    @(posedge clock_i) dac_clk <= 1'b1;
    repeat (3) @(posedge clock_i);
    dac_clk <= 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
  endtask : dac_latch
  // mid line: point stepping long finished, last column held
  task automatic line_mid;
    while (ln % 200 != 100)
      @(posedge clock_i);
  endtask : line_mid
  task automatic send(input logic [7:0] m, s, d, input bit mid);
    int n;
    @(posedge clock_i);
    main_a <= m;
    sub_a <= s;
    data <= d;
    start_i <= 1'b1;
    @(posedge clock_i);
    start_i <= 1'b0;
    #1;
    if (mid) begin
      dac_latch();
      chk_word("word in transfer", {3{6'h2a}});
    end
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(posedge clock_i);
      n++;
    end
    chk_flag("transfer done", 1'b1, n < 400);
    repeat (3) @(posedge clock_i);
    #1;
  endtask : send
  task automatic fill(input logic [7:0] m, d);
    for (int i = 0; i < MEM_WORDS; i++)
      send(m, 8'(i), d, i == 100);
  endtask : fill
  // ==========================================
  // test sequence
  initial begin
    repeat (10) @(posedge clock_i);
    rst_i <= 1'b0;
    #1;
    chk_word("word after reset", 18'h00000);
    chk_flag("oe_n after reset", 1'b0, oe_n);
    send(8'h08, REG_STANDBY_OFF_LEVEL, 8'h2a, 0);
    send(8'h08, REG_OUTPUT_CONTROL, 8'h18, 0);
    dac_latch();
    chk_word("word correction off", {3{6'h2a}});
    fill(8'h07, 8'hd5);
    send(8'h08, REG_OUTPUT_CONTROL, 8'hf8, 0);
    dac_latch();
    chk_word("word all memories", {3{6'h15}});
    fill(8'h02, 8'h0c);
    dac_latch();
    chk_word("word one memory", {6'h15, 6'h0c, 6'h15});
    send(8'h01, 8'h00, 8'h41, 0);
    send(8'h01, 8'hc0, 8'hc2, 0);
    line_mid();
    dac_latch();
    chk_word("word normal scan", {6'h15, 6'h0c, 6'h15});
    @(posedge clock_i);
    flip_sel  <= 1'b1;
    hflip_pin <= 1'b0;
    line_mid();
    dac_latch();
    chk_word("word column reversed", {6'h15, 6'h0c, 6'h01});
    @(posedge clock_i);
    vflip_pin <= 1'b0;
    line_mid();
    dac_latch();
    chk_word("word both reversed", {6'h15, 6'h0c, 6'h02});
    send(8'h08, REG_STANDBY_OFF_LEVEL, 8'haa, 0);
    chk_flag("oe_n in standby", 1'b1, oe_n);
    send(8'h08, REG_STANDBY_OFF_LEVEL, 8'h2a, 0);
    chk_flag("oe_n after standby", 1'b0, oe_n);
    @(posedge clock_i) rst_i <= 1'b1;
    @(posedge clock_i) rst_i <= 1'b0;
    #1;
    chk_word("word after second reset", 18'h00000);
    stop_test();
  end
  // watchdog against a hung transfer
  initial begin
    #700000; // tests need about 44k cycles
    n_mismatch++;
    stop_test();
  end
endmodule : test_shading_correction_generator
`default_nettype wire
